// ---- sd_data_path_pkg.sv ----
// constants for the memory-card data path register bank
package sd_data_path_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONFIG   = 8'h10;
    localparam logic [7:0] OFF_XFER     = 8'h14;
    localparam logic [7:0] OFF_CMD      = 8'h1C;
    localparam logic [7:0] OFF_IRQ_ST   = 8'h30;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
    localparam logic [7:0] OFF_DATA     = 8'h38;
    localparam logic [7:0] OFF_STATE    = 8'h3C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_BUS_W_LSB  = 12;
    localparam int CFG_TX_W_LSB   = 8;
    localparam int CFG_RX_W_LSB   = 6;
    localparam int CFG_ENABLE_BIT = 5;
    localparam int CFG_BLK_LSB    = 0;
    localparam int XFR_COUNT_LSB  = 16;
    localparam int XFR_ENA_BIT    = 1;
    localparam int XFR_DIR_BIT    = 0;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_BLOCK_BIT  = 1;

    // ------------------------------------------------------------
    // reset values, write masks and codes
    // ------------------------------------------------------------
    localparam logic [31:0] CONFIG_RST   = 32'h0000_0000;
    localparam logic [31:0] CONFIG_WMASK = 32'h0000_33EF;
    localparam logic [15:0] COUNT_RST    = 16'h0000;
    localparam logic [5:0]  CMD_RST      = 6'h00;
    localparam logic [1:0]  IRQ_RST      = 2'h0;
    localparam logic [1:0]  BUS_W_4      = 2'h1;
    localparam logic [1:0]  ACC_8        = 2'h0;
    localparam logic [1:0]  ACC_16       = 2'h1;

    typedef enum logic {ST_IDLE, ST_RUN} xfer_state_e;

endpackage

// ---- sd_data_path.sv ----
// memory-card data path: configuration, transfer control and lane shifter
//
// How it works
// - bus width code selects one or four lanes
// - receive word width 8, 16 or 32
// - transmit word width, same encoding
// - interface held inoperative while enable is clear
// - block length is two to block code
// - completion interrupt when byte count moved
// - count reads back bytes still remaining
// - datapath enable gates; direction selects read/write
// - command index write starts the transfer
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps

module sd_data_path
    import sd_data_path_pkg::*;
(
    input  logic        clk,
    input  logic        nrst,
    input  logic [7:0]  avAddress,
    input  logic        avRead,
    input  logic        avWrite,
    input  logic [31:0] avWriteData,
    input  logic [3:0]  avByteEnable,
    output logic [31:0] avReadData,
    output logic        avWaitRequest,
    input  logic        linkClk,
    input  logic [3:0]  datIn,
    output logic [3:0]  datOut,
    output logic [3:0]  datOe,
    output logic        irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0]  linkSync_q;
    logic [3:0]  datSync1_q;
    logic [3:0]  datSync2_q;
    logic        waitReq_q;
    logic [31:0] readData_q;
    logic [31:0] rdMux;
    logic [31:0] config_q;
    logic [15:0] count_q;
    logic        dataEna_q;
    logic        dirWrite_q;
    logic [5:0]  cmdIndex_q;
    logic [1:0]  irqSt_q;
    logic [1:0]  irqMask_q;
    logic        irq_q;
    xfer_state_e state_q;
    logic [7:0]  sh_q;
    logic [2:0]  bitPos_q;
    logic [14:0] blockCnt_q;
    logic [31:0] txWord_q;
    logic        txValid_q;
    logic [1:0]  txIdx_q;
    logic [31:0] rxWord_q;
    logic        rxValid_q;
    logic [1:0]  rxIdx_q;
    logic [3:0]  datOut_q;
    logic [3:0]  datOe_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // link clock and data lanes come from the card side; bit 0 of
    // linkSync_q is only ever read by bit 1
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkSync_q <= 3'h0;
            datSync1_q <= 4'h0;
            datSync2_q <= 4'h0;
        end else begin
            linkSync_q <= {linkSync_q[1:0], linkClk};
            datSync1_q <= datIn;
            datSync2_q <= datSync1_q;
        end
    end

    wire linkRise = linkSync_q[1] & ~linkSync_q[2];

    // ------------------------------------------------------------
    // avalon slave handshake
    // ------------------------------------------------------------
    wire        req    = avRead | avWrite;
    wire        acc    = req & ~waitReq_q;
    wire        wrAcc  = acc & avWrite;
    wire        rdAcc  = acc & avRead;
    wire [31:0] beMask = {{8{avByteEnable[3]}}, {8{avByteEnable[2]}},
                          {8{avByteEnable[1]}}, {8{avByteEnable[0]}}};
    wire [31:0] wrXfer = ({count_q, 14'h0, dataEna_q, dirWrite_q} & ~beMask)
                         | (avWriteData & beMask);
    wire        startPulse = wrAcc && (avAddress == OFF_CMD);

    // one wait cycle per access: read data is registered while waiting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waitReq_q  <= 1'b1;
            readData_q <= 32'h0000_0000;
        end else begin
            waitReq_q <= ~(req & waitReq_q);
            if (avRead && waitReq_q) begin
                readData_q <= rdMux;
            end
        end
    end

    // ------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------
    wire        ifEnable = config_q[CFG_ENABLE_BIT];
    wire        busWide  = config_q[CFG_BUS_W_LSB +: 2] == BUS_W_4;
    wire [3:0]  blkCode  = config_q[CFG_BLK_LSB +: 4];
    wire [15:0] blkMax   = (16'h1 << blkCode) - 16'h1;
    wire        blockLast = {1'b0, blockCnt_q} == blkMax;
    wire [3:0]  laneMask = busWide ? 4'hF : 4'h1;
    wire [3:0]  stepBits = busWide ? 4'h4 : 4'h1;

    // last byte slot in a word for a width code; reserved code acts as 32
    function automatic logic [1:0] lastSlot(input logic [1:0] code);
        lastSlot = (code == ACC_8) ? 2'h0 : (code == ACC_16) ? 2'h1 : 2'h3;
    endfunction

    wire [1:0] txLast = lastSlot(config_q[CFG_TX_W_LSB +: 2]);
    wire [1:0] rxLast = lastSlot(config_q[CFG_RX_W_LSB +: 2]);

    // ------------------------------------------------------------
    // configuration, control and command registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            config_q <= CONFIG_RST;
        end else if (wrAcc && avAddress == OFF_CONFIG) begin
            config_q <= ((config_q & ~beMask) | (avWriteData & beMask)) & CONFIG_WMASK;
        end
    end

    // ------------------------------------------------------------
    // shifter step conditions
    // ------------------------------------------------------------
    wire [3:0] posSum  = {1'b0, bitPos_q} + stepBits;
    // a write stalls with no word ready, a read stalls on an unread word
    wire       canStep = dirWrite_q ? (bitPos_q != 3'h0 || txValid_q) : !rxValid_q;
    wire       shift   = (state_q == ST_RUN) && ifEnable && linkRise && canStep;
    wire       byteDone = shift && posSum[3];
    wire       doneEvt  = byteDone && (count_q == 16'h0001);
    wire       blockEvt = byteDone && blockLast;
    wire [7:0] txByte  = txWord_q[{txIdx_q, 3'h0} +: 8];
    wire [7:0] src     = (bitPos_q == 3'h0) ? txByte : sh_q;
    wire [7:0] rxByte  = busWide ? {sh_q[3:0], datSync2_q} : {sh_q[6:0], datSync2_q[0]};

    // transfer control; a software write wins over the running decrement
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_q    <= COUNT_RST;
            dataEna_q  <= 1'b0;
            dirWrite_q <= 1'b0;
        end else if (wrAcc && avAddress == OFF_XFER) begin
            count_q    <= wrXfer[XFR_COUNT_LSB +: 16];
            dataEna_q  <= wrXfer[XFR_ENA_BIT];
            dirWrite_q <= wrXfer[XFR_DIR_BIT];
        end else if (byteDone) begin
            count_q <= count_q - 16'h0001;
        end
    end

    // command index is stored; the write itself launches the datapath
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmdIndex_q <= CMD_RST;
        end else if (startPulse) begin
            cmdIndex_q <= avWriteData[5:0];
        end
    end

    // ------------------------------------------------------------
    // transfer state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (startPulse && ifEnable && dataEna_q && count_q != 16'h0) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!ifEnable || doneEvt) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // bit shifter and block counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh_q       <= 8'h00;
            bitPos_q   <= 3'h0;
            blockCnt_q <= 15'h0;
        end else if (state_q == ST_IDLE) begin
            bitPos_q   <= 3'h0;
            blockCnt_q <= 15'h0;
        end else if (shift) begin
            bitPos_q <= posSum[2:0];
            if (dirWrite_q) begin
                sh_q <= busWide ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
            end else begin
                sh_q <= rxByte;
            end
            if (posSum[3]) begin
                blockCnt_q <= blockLast ? 15'h0 : blockCnt_q + 15'h1;
            end
        end
    end

    // lane drivers; a read never drives, disable releases at once
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            datOut_q <= 4'h0;
            datOe_q  <= 4'h0;
        end else begin
            datOe_q <= (state_q == ST_RUN && ifEnable && dirWrite_q) ? laneMask : 4'h0;
            if (shift && dirWrite_q) begin
                datOut_q <= busWide ? src[7:4] : {3'h0, src[7]};
            end
        end
    end

    // ------------------------------------------------------------
    // software data words
    // ------------------------------------------------------------
    // width is read live, so a change mid-word misaligns the slot index
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txWord_q  <= 32'h0000_0000;
            txValid_q <= 1'b0;
            txIdx_q   <= 2'h0;
        end else if (wrAcc && avAddress == OFF_DATA) begin
            txWord_q  <= avWriteData;
            txValid_q <= 1'b1;
            txIdx_q   <= 2'h0;
        end else if (shift && dirWrite_q && bitPos_q == 3'h0) begin
            txValid_q <= txIdx_q != txLast;
            txIdx_q   <= (txIdx_q == txLast) ? 2'h0 : txIdx_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxWord_q  <= 32'h0000_0000;
            rxValid_q <= 1'b0;
            rxIdx_q   <= 2'h0;
        end else if (byteDone && !dirWrite_q) begin
            rxWord_q[{rxIdx_q, 3'h0} +: 8] <= rxByte;
            rxValid_q <= rxIdx_q == rxLast;
            rxIdx_q   <= (rxIdx_q == rxLast) ? 2'h0 : rxIdx_q + 2'h1;
        end else if (rdAcc && avAddress == OFF_DATA) begin
            rxValid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqSt_q   <= IRQ_RST;
            irqMask_q <= IRQ_RST;
            irq_q     <= 1'b0;
        end else begin
            irqSt_q <= (irqSt_q & ~((wrAcc && avAddress == OFF_IRQ_ST && avByteEnable[0])
                                    ? avWriteData[1:0] : 2'h0))
                       | {blockEvt, doneEvt};
            if (wrAcc && avAddress == OFF_IRQ_MASK && avByteEnable[0]) begin
                irqMask_q <= avWriteData[1:0];
            end
            irq_q <= |(irqSt_q & irqMask_q);
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        case (avAddress)
            OFF_CONFIG:   rdMux = config_q;
            OFF_XFER:     rdMux = {count_q, 14'h0, dataEna_q, dirWrite_q};
            OFF_CMD:      rdMux = {26'h0, cmdIndex_q};
            OFF_IRQ_ST:   rdMux = {30'h0, irqSt_q};
            OFF_IRQ_MASK: rdMux = {30'h0, irqMask_q};
            OFF_DATA:     rdMux = rxWord_q;
            OFF_STATE:    rdMux = {29'h0, rxValid_q, txValid_q, state_q == ST_RUN};
            default:      rdMux = 32'h0000_0000;
        endcase
    end

    assign avReadData    = readData_q;
    assign avWaitRequest = waitReq_q;
    assign datOut        = datOut_q;
    assign datOe         = datOe_q;
    assign irq           = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_disable_idle: assert property (
        !ifEnable |=> state_q == ST_IDLE && datOe_q == 4'h0)
        else $error("interface active while disabled");
    a_lane_count: assert property (
        state_q == ST_RUN && ifEnable && dirWrite_q |=> datOe_q == $past(laneMask))
        else $error("wrong lane drive for bus width");
    a_read_no_drive: assert property (
        state_q == ST_RUN && !dirWrite_q |=> datOe_q == 4'h0)
        else $error("lanes driven during a read");
    a_start_run: assert property (
        state_q == ST_IDLE && startPulse && ifEnable && dataEna_q && count_q != 16'h0
        |=> state_q == ST_RUN)
        else $error("command write did not start transfer");
    a_gate_idle: assert property (
        state_q == ST_IDLE && !(startPulse && dataEna_q) |=> state_q == ST_IDLE)
        else $error("datapath ran without enable and command");
    a_count_dec: assert property (
        byteDone && !(wrAcc && avAddress == OFF_XFER) |=> count_q == $past(count_q) - 16'h1)
        else $error("remaining count not decremented");
    a_done_flag: assert property (
        doneEvt |=> irqSt_q[IRQ_DONE_BIT] && state_q == ST_IDLE)
        else $error("completion not flagged");
    a_block_wrap: assert property (
        byteDone |=> blockCnt_q == ($past(blockLast) ? 15'h0 : $past(blockCnt_q) + 15'h1))
        else $error("block counter off length");
    a_rx_width: assert property (
        byteDone && !dirWrite_q && rxIdx_q == rxLast |=> rxValid_q)
        else $error("receive word not completed at width");
    a_tx_width: assert property (
        shift && dirWrite_q && bitPos_q == 3'h0 && txIdx_q == txLast
        && !(wrAcc && avAddress == OFF_DATA) |=> !txValid_q)
        else $error("transmit word not released at width");

    c_write_run: cover property (startPulse && dirWrite_q ##1 state_q == ST_RUN);
    c_read_run: cover property (startPulse && !dirWrite_q ##1 state_q == ST_RUN);
    c_block_end: cover property (blockEvt && !doneEvt);
    c_done: cover property (doneEvt ##[1:4] irq_q);

endmodule

// ---- sd_card_model.sv ----
// behavioural memory card on the far side of the data lanes
`timescale 1ns/1ps

module sd_card_model (
    output logic        linkClk,
    output logic [3:0]  datIn,
    input  wire  [3:0]  datOut,
    output logic [31:0] gotWord
);
    // ------------------------------------------------------------
    // idle lines: clock low, data lanes pulled up
    // ------------------------------------------------------------
    initial begin
        linkClk = 1'b0;
        datIn   = 4'hF;
        gotWord = 32'h0000_0000;
    end

    // lanes driven for one step, msb first
    function automatic logic [3:0] lanes(input logic wide, input logic [31:0] s);
        return wide ? s[31:28] : {3'b111, s[31]};
    endfunction

    // one frame of n rises; the clock stands still between frames
    task automatic frame(input int n, input logic wide, input logic [31:0] sendWord);
        logic [31:0] sh;
        sh = sendWord;
        #13;                                   // phase unrelated to the system clock
        datIn = lanes(wide, sh);
        for (int i = 0; i < n; i++) begin
            linkClk = 1'b1;
            #100;
            linkClk = 1'b0;
            sh = wide ? sh << 4 : sh << 1;
            // new data only after the fall, so it holds across the late sampling
            datIn = (i == n - 1) ? 4'hF : lanes(wide, sh);
            #75;
            // sample late: the block answers several system clocks after a rise
            gotWord = wide ? {gotWord[27:0], datOut} : {gotWord[30:0], datOut[0]};
            #25;
        end
    endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the memory-card data path register bank
`timescale 1ns/1ps

module tb;
    import sd_data_path_pkg::*;

    logic        clk;
    logic        nrst;
    logic [7:0]  avAddress;
    logic        avRead;
    logic        avWrite;
    logic [31:0] avWriteData;
    logic [3:0]  avByteEnable;
    logic [31:0] avReadData;
    logic        avWaitRequest;
    logic        linkClk;
    logic [3:0]  datIn;
    logic [3:0]  datOut;
    logic [3:0]  datOe;
    logic        irq;
    int          failures;
    int          cmpCount;
    int          seed;
    logic [31:0] expQ[$];

    sd_data_path dut_u (.clk(clk), .nrst(nrst), .avAddress(avAddress), .avRead(avRead),
        .avWrite(avWrite), .avWriteData(avWriteData), .avByteEnable(avByteEnable),
        .avReadData(avReadData), .avWaitRequest(avWaitRequest), .linkClk(linkClk),
        .datIn(datIn), .datOut(datOut), .datOe(datOe), .irq(irq));

    sd_card_model card_u (.linkClk(linkClk), .datIn(datIn), .datOut(datOut), .gotWord());

    // ------------------------------------------------------------
    // clock, compare, verdict
    // ------------------------------------------------------------
    always #12.5 clk = ~clk;

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && cmpCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // read data is taken at the edge where waitrequest is seen low
    always @(posedge clk) begin
        if (avRead === 1'b1 && avWaitRequest === 1'b0) begin
            check("avReadData", expQ.pop_front(), avReadData);
        end
    end

    // ------------------------------------------------------------
    // bus master tasks
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        avAddress    <= a;
        avWrite      <= wr;
        avRead       <= ~wr;
        avWriteData  <= d;
        avByteEnable <= be;
        // no wait count is assumed; only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (avWaitRequest !== 1'b0);
        avRead  <= 1'b0;
        avWrite <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask

    // pins are looked at away from the edge, once its updates have landed
    task automatic pin(input string what, input logic [3:0] e, input logic [3:0] g);
        @(negedge clk);
        check(what, {28'h0, e}, {28'h0, g});
    endtask

    // a hang is cut short far past the few tens of microseconds of traffic
    initial begin
        #400_000;
        failures++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic [31:0] rxw;
        logic [7:0]  b;
        seed = 32'hBD98;
        failures = 0;
        cmpCount = 0;
        clk = 1'b0;
        nrst = 1'b0;
        avAddress = 8'h00;
        avRead = 1'b0;
        avWrite = 1'b0;
        avWriteData = 32'h0000_0000;
        avByteEnable = 4'h0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        pin("datOe", 4'h0, datOe);
        pin("irq", 4'h0, {3'h0, irq});
        // reset values, unmapped place, reserved bits
        rd(OFF_CONFIG, CONFIG_RST);
        rd(OFF_XFER, 32'h0000_0000);
        rd(OFF_IRQ_ST, 32'h0000_0000);
        rd(OFF_IRQ_MASK, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        wr(OFF_XFER, 32'hFFFF_FFFC);
        rd(OFF_XFER, 32'hFFFF_0000);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(OFF_CONFIG, v);
            rd(OFF_CONFIG, v & CONFIG_WMASK);
        end
        bus(1'b1, OFF_CONFIG, 32'h0000_0000, 4'h1);
        rd(OFF_CONFIG, v & CONFIG_WMASK & 32'hFFFF_FF00);
        // interface disabled, then datapath disabled: no run may start
        for (int k = 0; k < 2; k++) begin
            wr(OFF_CONFIG, k ? 32'h0000_0222 : 32'h0000_0202);
            wr(OFF_XFER, k ? 32'h0004_0001 : 32'h0004_0003);
            wr(OFF_CMD, 32'h0000_0011);
            rd(OFF_CMD, 32'h0000_0011);
            rd(OFF_STATE, 32'h0000_0000);
            pin("datOe", 4'h0, datOe);
        end
        // card writes: one lane with 32-bit words and 4-byte blocks, then
        // four lanes with 16-bit words and 2-byte blocks, paused mid-way
        for (int m = 0; m < 2; m++) begin
            v = $random(seed);
            wr(OFF_IRQ_MASK, m ? 32'h0 : 32'h1);
            wr(OFF_CONFIG, m ? 32'h0000_1121 : 32'h0000_0222);
            wr(OFF_DATA, v);
            wr(OFF_XFER, 32'h0004_0003);
            wr(OFF_CMD, 32'h0000_0011);
            card_u.frame(m ? 4 : 8, m[0], 32'hFFFF_FFFF);
            pin("datOe", m ? 4'hF : 4'h1, datOe);
            rd(OFF_XFER, m ? 32'h0002_0003 : 32'h0003_0003);
            rd(OFF_IRQ_ST, m ? 32'h0000_0002 : 32'h0000_0000);
            rd(OFF_STATE, m ? 32'h0000_0001 : 32'h0000_0003);
            // a 16-bit word is spent after two bytes; the run stalls until refilled
            if (m) begin
                wr(OFF_DATA, v >> 16);
            end
            card_u.frame(m ? 4 : 24, m[0], 32'hFFFF_FFFF);
            check("gotWord", {v[7:0], v[15:8], v[23:16], v[31:24]}, card_u.gotWord);
            rd(OFF_XFER, 32'h0000_0003);
            rd(OFF_IRQ_ST, 32'h0000_0003);
            pin("irq", m ? 4'h0 : 4'h1, {3'h0, irq});
            wr(OFF_IRQ_ST, 32'h0000_0003);
            rd(OFF_IRQ_ST, 32'h0000_0000);
            pin("irq", 4'h0, {3'h0, irq});
        end
        // card reads: 8-bit words on one lane, 16-bit words on four
        for (int m = 0; m < 2; m++) begin
            rxw = 32'h0;
            wr(OFF_CONFIG, 32'h0000_0021 | (32'(m) << 12) | (32'(m) << 6));
            wr(OFF_XFER, 32'h0002_0002);
            wr(OFF_CMD, 32'h0000_0022);
            for (int j = 0; j < 2; j++) begin
                b = $random(seed);
                card_u.frame(m ? 2 : 8, m[0], {b, 24'h0});
                pin("datOe", 4'h0, datOe);
                rxw = m ? rxw | (32'(b) << (8 * j)) : {24'h0, b};
                rd(OFF_STATE, (m && j == 0) ? 32'h1 : (j ? 32'h4 : 32'h5));
                if (!m || j) begin
                    rd(OFF_DATA, rxw);
                end
            end
            rd(OFF_XFER, 32'h0000_0002);
            rd(OFF_IRQ_ST, 32'h0000_0003);
            wr(OFF_IRQ_ST, 32'h0000_0003);
        end
        print_verdict();
    end
endmodule
